// ---- core/spd_path_pkg.sv ----
// shared constants and types for the velocity-mode speed command path
package spd_path_pkg;
    // register word addresses
    localparam logic [3:0] A_CTRL_TYPE = 4'h0;
    localparam logic [3:0] A_KP        = 4'h1;
    localparam logic [3:0] A_TI        = 4'h2;
    localparam logic [3:0] A_SOURCE    = 4'h3;
    localparam logic [3:0] A_SCALE     = 4'h4;
    localparam logic [3:0] A_OFFSET    = 4'h5;
    localparam logic [3:0] A_DEADBAND  = 4'h6;
    localparam logic [3:0] A_LOWPASS   = 4'h7;
    localparam logic [3:0] A_ACCEL     = 4'h8;
    localparam logic [3:0] A_DECEL     = 4'h9;
    localparam logic [3:0] A_POS_LIMIT = 4'ha;
    localparam logic [3:0] A_MODE      = 4'hb;
    localparam logic [3:0] A_INT_SPEED = 4'hc;
    localparam logic [3:0] A_STATUS    = 4'hd;
    localparam logic [3:0] A_MASK      = 4'he;
    localparam logic [3:0] A_SPEED     = 4'hf;
    // reset values
    localparam logic [15:0] RST_CTRL_TYPE = 16'h0002;
    localparam logic [15:0] RST_KP        = 16'h00b7;
    localparam logic [15:0] RST_TI        = 16'h00bd;
    localparam logic [15:0] RST_SCALE     = 16'h0032;
    localparam logic [15:0] RST_LOWPASS   = 16'h03e8;
    localparam logic [15:0] RST_RAMP      = 16'h0064;
    localparam logic [31:0] RST_POS_LIMIT = 32'h0000_ffff;
    // legal value limits
    localparam logic [15:0] GAIN_MAX  = 16'h7530;
    localparam logic [15:0] SCALE_MAX = 16'h0064;
    localparam logic [15:0] DB_MAX    = 16'h00ff;
    localparam logic [15:0] LPF_MAX   = 16'h4e20;
    localparam logic [15:0] RAMP_MAX  = 16'h1388;
    localparam logic [15:0] RAMP_MIN  = 16'h0001;
    localparam logic signed [16:0] MV_MAX = 17'h02710;
    localparam logic signed [16:0] MV_MIN = -17'sh02710;
    // field codes
    localparam logic [15:0] CT_POS_TIME   = 16'h0001;
    localparam logic [15:0] CT_SPEED_ONLY = 16'h0002;
    localparam logic [15:0] SRC_INTERNAL  = 16'h0000;
    localparam logic [15:0] SRC_ANALOG    = 16'h0001;
    localparam int ST_POS_ERR = 0;
    localparam int ST_REACHED = 1;
    // filter gain in q16 per 0.1 Hz of cutoff at the filter sample rate
    localparam logic [17:0] LPF_ALPHA = 18'h00004;
    // speed divisor: mV times 0.1 rps/V gives 0.001 rps after this
    localparam logic signed [31:0] SCALE_DIV = 32'sh0000000a;
    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int FILT_PERIOD_NS = 100000;
    localparam int FILT_CYCLES    = FILT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RAMP_PERIOD_NS = 1000000;
    localparam int RAMP_CYCLES    = RAMP_PERIOD_NS / CLK_PERIOD_NS;
    // drive mode of the velocity command
    typedef enum logic [1:0] {
        MODE_OTHER     = 2'b00,
        MODE_INT_SPEED = 2'b01,
        MODE_ANA_SPEED = 2'b10
    } drive_mode_t;
    // millivolt sample
    typedef logic signed [16:0] mv_t;
    // register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;
endpackage

// ---- core/lowpass_filter.sv ----
// first-order low-pass filter for the corrected analog sample
`timescale 1ns/1ps
module lowpass_filter (
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    input  wire logic              stb_i,
    input  wire logic [15:0]       cutoff_i,
    input  wire spd_path_pkg::mv_t x_i,
    output spd_path_pkg::mv_t      y_o
);
    import spd_path_pkg::*;

    // accumulator in q16 millivolts
    typedef struct packed {
        logic signed [33:0] acc;
    } filt_state_t;

    filt_state_t        s;      // registered state
    filt_state_t        next_s; // next state
    logic        [17:0] alpha;  // step coefficient, q16
    logic signed [34:0] diff;   // input minus accumulator
    logic signed [53:0] prod;   // scaled difference

    // one update per sample strobe
    always_comb begin
        next_s = s;
        alpha  = 18'({2'b00, cutoff_i} * LPF_ALPHA);
        diff   = {{2{x_i[16]}}, x_i, 16'h0000} - {s.acc[33], s.acc};
        prod   = diff * $signed({1'b0, alpha});
        if (stb_i) begin
            // zero cutoff or one whose step coefficient reaches 1.0 (cutoff 16384 and up) passes straight
            if (cutoff_i == 16'h0000 || alpha[17:16] != 2'b00) begin
                next_s.acc = {x_i[16], x_i, 16'h0000};
            end else begin
                next_s.acc = s.acc + 34'(prod >>> 16);
            end
        end
    end

    // state register, frozen while the enable is low
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign y_o = s.acc[32:16]; // flop output
endmodule

// ---- core/speed_cmd_path.sv ----
// velocity-mode control type and analog speed command conditioning
`timescale 1ns/1ps
// Behaviour
// - control type 1 or 2, default 2
// - type 1 flags fault on position error
// - type 2 never flags position error
// - speed-only uses loop gain and integral time
// - source select: 0 internal, 1 analog
// - analog speed mode forces analog source
// - analog scaled linearly, scale 0..100 0.1rps/V
// - signed millivolt offset corrects analog input
// - input inside deadband counts as zero
// - analog input passes low-pass filter
// - speed rise limited by acceleration rate
// - speed fall limited by deceleration rate
module speed_cmd_path #(
    parameter int RAMP_CYCLES = spd_path_pkg::RAMP_CYCLES
) (
    input  wire logic                     core_clk_i,
    input  wire logic                     srst_i,
    input  wire logic                     ce_i,
    input  wire spd_path_pkg::bus_req_t   bus_i,
    output logic [31:0]                   rd_data_o,
    input  wire logic signed [15:0]       analog_cmd_input_i,
    input  wire logic signed [31:0]       cmd_pos_i,
    input  wire logic signed [31:0]       act_pos_i,
    output logic signed [31:0]            target_speed_o,
    output logic [15:0]                   loop_prop_gain_o,
    output logic [15:0]                   loop_integral_time_o,
    output logic                          speed_loop_en_o,
    output logic                          pos_fault_o,
    output logic                          irq_o
);
    import spd_path_pkg::*;

    // whole state of the block
    typedef struct packed {
        logic [15:0]        ctrl_type;   // control_type_select
        logic [15:0]        kp;          // loop_prop_gain
        logic [15:0]        ti;          // loop_integral_time
        logic [15:0]        source;      // command_source_select
        logic [15:0]        scale;       // volts_to_speed_scale
        logic signed [15:0] offset;      // input_offset_mv
        logic [15:0]        deadband;    // input_deadband_mv
        logic [15:0]        lowpass;     // input_lowpass_cutoff
        logic [15:0]        accel;       // ramp_accel_rate
        logic [15:0]        decel;       // ramp_decel_rate
        logic [31:0]        pos_limit;   // position_error_limit
        drive_mode_t        mode;        // drive mode
        logic signed [31:0] int_speed;   // internal command, 0.001 rps
        logic [1:0]         status;      // sticky events
        logic [1:0]         mask;        // interrupt enables
        logic signed [31:0] speed;       // ramped target, 0.001 rps
        logic signed [31:0] ana_speed;   // scaled analog command
        mv_t                sample;      // corrected, deadbanded input
        logic               filt_stb;    // sample ready for the filter
        logic [15:0]        filt_cnt;    // filter sample divider
        logic [31:0]        ramp_cnt;    // ramp tick divider
        logic [31:0]        rd_data;     // read answer
        logic               loop_en;     // speed-only loop active
        logic               irq;         // interrupt level
    } path_state_t;

    localparam path_state_t S_RST = '{
        ctrl_type: RST_CTRL_TYPE, kp: RST_KP, ti: RST_TI,
        source: SRC_INTERNAL, scale: RST_SCALE, offset: '0,
        deadband: '0, lowpass: RST_LOWPASS, accel: RST_RAMP,
        decel: RST_RAMP, pos_limit: RST_POS_LIMIT, mode: MODE_OTHER,
        int_speed: '0, status: '0, mask: '0, speed: '0,
        ana_speed: '0, sample: '0, filt_stb: 1'b0, filt_cnt: '0,
        ramp_cnt: '0, rd_data: '0, loop_en: 1'b1, irq: 1'b0
    };

    path_state_t        s;         // registered state
    path_state_t        next_s;    // next state
    mv_t                filt_y;    // filter output, mV
    logic signed [32:0] pos_diff;  // command minus actual position
    logic               pos_err;   // error beyond limit this cycle
    logic               ramp_now;  // ramp tick this cycle

    // magnitude of a signed 33-bit value
    function automatic logic [32:0] abs33(input logic signed [32:0] v);
        return v[32] ? 33'(-v) : 33'(v);
    endfunction

    // unsigned range test for a register write
    function automatic logic in_range(input logic [31:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        return v >= {16'h0000, lo} && v <= {16'h0000, hi};
    endfunction

    // filter stage between the deadband and the scaler
    lowpass_filter u_filter (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .stb_i      (s.filt_stb),
        .cutoff_i   (s.lowpass),
        .x_i        (s.sample),
        .y_o        (filt_y)
    );

    // position error seen only in position-over-time control
    assign pos_diff = 33'(cmd_pos_i) - 33'(act_pos_i);
    assign pos_err  = (s.ctrl_type == CT_POS_TIME) &&
                      (abs33(pos_diff) > {1'b0, s.pos_limit});
    assign ramp_now = (s.ramp_cnt == 32'(RAMP_CYCLES - 1));

    // next-state logic: bus, analog chain, ramp, events
    always_comb begin
        logic signed [16:0] corr;    // offset-corrected input
        logic signed [31:0] sel;     // selected command
        logic signed [31:0] dlt;     // selected minus current
        logic        [31:0] rate;    // allowed step this tick
        logic               away;    // moving away from zero
        logic        [1:0]  events;  // events this cycle
        corr   = '0;
        sel    = '0;
        dlt    = '0;
        rate   = '0;
        away   = 1'b0;
        events = '0;
        next_s = s;

        // register writes; illegal values are dropped
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                A_CTRL_TYPE: begin
                    if (in_range(bus_i.wdata, CT_POS_TIME,
                                 CT_SPEED_ONLY)) begin
                        next_s.ctrl_type = bus_i.wdata[15:0];
                    end
                end
                A_KP: begin
                    if (in_range(bus_i.wdata, 16'h0000, GAIN_MAX)) begin
                        next_s.kp = bus_i.wdata[15:0];
                    end
                end
                A_TI: begin
                    if (in_range(bus_i.wdata, 16'h0000, GAIN_MAX)) begin
                        next_s.ti = bus_i.wdata[15:0];
                    end
                end
                A_SOURCE: begin
                    if (in_range(bus_i.wdata, SRC_INTERNAL,
                                 SRC_ANALOG)) begin
                        next_s.source = bus_i.wdata[15:0];
                    end
                end
                A_SCALE: begin
                    if (in_range(bus_i.wdata, 16'h0000, SCALE_MAX)) begin
                        next_s.scale = bus_i.wdata[15:0];
                    end
                end
                A_OFFSET: begin
                    // signed 16-bit value within plus or minus 10 V
                    if ($signed(bus_i.wdata[15:0]) >= MV_MIN &&
                        $signed(bus_i.wdata[15:0]) <= MV_MAX) begin
                        next_s.offset = bus_i.wdata[15:0];
                    end
                end
                A_DEADBAND: begin
                    if (in_range(bus_i.wdata, 16'h0000, DB_MAX)) begin
                        next_s.deadband = bus_i.wdata[15:0];
                    end
                end
                A_LOWPASS: begin
                    if (in_range(bus_i.wdata, 16'h0000, LPF_MAX)) begin
                        next_s.lowpass = bus_i.wdata[15:0];
                    end
                end
                A_ACCEL: begin
                    if (in_range(bus_i.wdata, RAMP_MIN, RAMP_MAX)) begin
                        next_s.accel = bus_i.wdata[15:0];
                    end
                end
                A_DECEL: begin
                    if (in_range(bus_i.wdata, RAMP_MIN, RAMP_MAX)) begin
                        next_s.decel = bus_i.wdata[15:0];
                    end
                end
                A_POS_LIMIT: next_s.pos_limit = bus_i.wdata;
                A_MODE: begin
                    // code 3 is not a mode and is dropped
                    if (bus_i.wdata[1:0] != 2'b11) begin
                        next_s.mode = drive_mode_t'(bus_i.wdata[1:0]);
                    end
                end
                A_INT_SPEED: next_s.int_speed = bus_i.wdata;
                A_STATUS:    next_s.status = s.status & ~bus_i.wdata[1:0];
                A_MASK:      next_s.mask = bus_i.wdata[1:0];
                A_SPEED:     begin end // read only, writes dropped
            endcase
        end

        // analog speed mode holds the analog source
        if (next_s.mode == MODE_ANA_SPEED) begin
            next_s.source = SRC_ANALOG;
        end

        // analog chain: offset and clamp, then deadband, per sample
        next_s.filt_stb = 1'b0;
        if (s.filt_cnt == 16'(FILT_CYCLES - 1)) begin
            next_s.filt_cnt = '0;
            next_s.filt_stb = 1'b1;
            corr = 17'(analog_cmd_input_i) - 17'(s.offset);
            if (corr > MV_MAX) begin
                corr = MV_MAX;
            end else if (corr < MV_MIN) begin
                corr = MV_MIN;
            end
            if (abs33(33'(corr)) <= {17'h00000, s.deadband}) begin
                corr = '0;
            end
            next_s.sample = corr;
        end else begin
            next_s.filt_cnt = s.filt_cnt + 16'h0001;
        end

        // filtered millivolts to 0.001 rps, linear over the range
        next_s.ana_speed = (32'(filt_y) * $signed({16'h0000, s.scale}))
                           / SCALE_DIV;

        // ramp toward the selected command
        sel = (s.source == SRC_ANALOG) ? s.ana_speed : s.int_speed;
        dlt = sel - s.speed;
        away = (s.speed >= 0 && sel > s.speed) ||
               (s.speed <= 0 && sel < s.speed);
        rate = away ? {16'h0000, s.accel} : {16'h0000, s.decel};
        next_s.ramp_cnt = ramp_now ? '0 : s.ramp_cnt + 32'h0000_0001;
        if (s.mode == MODE_OTHER) begin
            // no ramp outside the speed modes
            next_s.speed = sel;
        end else if (ramp_now && dlt != 0) begin
            // rate in rps/s equals 0.001 rps per 1 ms tick
            if (abs33(33'(dlt)) <= {1'b0, rate}) begin
                next_s.speed = sel;
                events[ST_REACHED] = 1'b1;
            end else if (dlt > 0) begin
                next_s.speed = s.speed + $signed(rate);
            end else begin
                next_s.speed = s.speed - $signed(rate);
            end
        end

        // sticky events: a set in the clearing cycle wins
        events[ST_POS_ERR] = pos_err;
        next_s.status  = next_s.status | events;
        next_s.irq     = |(next_s.status & next_s.mask);
        next_s.loop_en = (next_s.ctrl_type == CT_SPEED_ONLY);

        // read answer stands for one cycle only
        next_s.rd_data = '0;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                A_CTRL_TYPE: next_s.rd_data = {16'h0000, s.ctrl_type};
                A_KP:        next_s.rd_data = {16'h0000, s.kp};
                A_TI:        next_s.rd_data = {16'h0000, s.ti};
                A_SOURCE:    next_s.rd_data = {16'h0000, s.source};
                A_SCALE:     next_s.rd_data = {16'h0000, s.scale};
                A_OFFSET:    next_s.rd_data = {16'h0000, s.offset};
                A_DEADBAND:  next_s.rd_data = {16'h0000, s.deadband};
                A_LOWPASS:   next_s.rd_data = {16'h0000, s.lowpass};
                A_ACCEL:     next_s.rd_data = {16'h0000, s.accel};
                A_DECEL:     next_s.rd_data = {16'h0000, s.decel};
                A_POS_LIMIT: next_s.rd_data = s.pos_limit;
                A_MODE:      next_s.rd_data = {30'h0, s.mode};
                A_INT_SPEED: next_s.rd_data = s.int_speed;
                A_STATUS:    next_s.rd_data = {30'h0, s.status};
                A_MASK:      next_s.rd_data = {30'h0, s.mask};
                A_SPEED:     next_s.rd_data = s.speed;
            endcase
        end
    end

    // state register, frozen while the enable is low
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s <= S_RST;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign rd_data_o            = s.rd_data;
    assign target_speed_o       = s.speed;
    assign loop_prop_gain_o     = s.kp;
    assign loop_integral_time_o = s.ti;
    assign speed_loop_en_o      = s.loop_en;
    assign pos_fault_o          = s.status[ST_POS_ERR];
    assign irq_o                = s.irq;

    default clocking dflt_cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    // control type only ever holds a legal code
    type_legal_a: assert property (
        s.ctrl_type == CT_POS_TIME || s.ctrl_type == CT_SPEED_ONLY)
        else $error("control type left 1 and 2");
    // an error under type 1 raises the fault next cycle
    pos_err_set_a: assert property (
        ce_i && s.ctrl_type == CT_POS_TIME &&
        abs33(pos_diff) > {1'b0, s.pos_limit} |=> pos_fault_o)
        else $error("position error did not raise the fault");
    // a fault only rises from a type 1 error
    no_err_speed_a: assert property (
        $rose(pos_fault_o) |-> $past(s.ctrl_type) == CT_POS_TIME)
        else $error("fault raised without position control type");
    // loop enable follows the speed-only type, gains stay within GAIN_MAX
    loop_gain_a: assert property (
        ##1 speed_loop_en_o == (s.ctrl_type == CT_SPEED_ONLY) &&
        loop_prop_gain_o <= GAIN_MAX && loop_integral_time_o <= GAIN_MAX)
        else $error("speed loop gains out of step");
    // analog mode always selects the analog input
    src_force_a: assert property (
        s.mode == MODE_ANA_SPEED |-> s.source == SRC_ANALOG &&
        s.source <= SRC_ANALOG)
        else $error("analog mode without analog source");
    // scaled command tracks filter output times scale
    scale_path_a: assert property (
        ce_i ##1 ce_i |-> s.ana_speed ==
        (32'($past(filt_y)) * $signed({16'h0000, $past(s.scale)}))
        / SCALE_DIV)
        else $error("analog speed scaling wrong");
    // corrected sample stays inside plus or minus 10 V
    offset_clamp_a: assert property (
        s.filt_stb |-> s.sample <= MV_MAX && s.sample >= MV_MIN)
        else $error("corrected sample out of range");
    // a nonzero sample lies outside the deadband
    // judged against the deadband of the loading cycle, since a write
    // landing on that same edge must not count against the sample
    deadband_zero_a: assert property (
        $past(ce_i) && s.filt_stb && s.sample != 0 |->
        abs33(33'(s.sample)) > {17'h00000, $past(s.deadband)})
        else $error("sample inside deadband not zeroed");
    // on a ramp tick outside MODE_OTHER, speed steps no more than the larger ramp rate
    ramp_step_a: assert property (
        ce_i && ramp_now && s.mode != MODE_OTHER |=>
        abs33(33'(s.speed - $past(s.speed))) <=
        {17'h00000, ($past(s.accel) > $past(s.decel)) ?
         $past(s.accel) : $past(s.decel)})
        else $error("ramp step exceeds rate");

    cover_fault_c:   cover property ($rose(pos_fault_o));
    cover_reach_c:   cover property (s.status[ST_REACHED] && irq_o);
    cover_analog_c:  cover property (s.mode == MODE_ANA_SPEED &&
                                     s.speed != 0);
endmodule

// ---- sim/analog_src_model.sv ----
// analog command source and encoder model for the speed path bench
`timescale 1ns/1ps
module analog_src_model (
    input  wire logic               core_clk_i,
    input  wire logic signed [15:0] level_i,
    input  wire logic signed [31:0] pos_i,
    output logic signed [15:0]      mv_o,
    output logic signed [31:0]      act_pos_o
);
    // a settled source: both values start at zero
    initial begin
        mv_o      = '0;
        act_pos_o = '0;
    end
    // values change only just after a rising edge, never mid-cycle
    always @(posedge core_clk_i) begin
        mv_o      <= level_i;
        act_pos_o <= pos_i;
    end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the speed command path
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    num_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
    import spd_path_pkg::*;
    logic               core_clk_i = 0;  // 10 mhz core clock
    logic               srst_i     = 1;  // held for 16 cycles
    logic               ce         = 1;  // clock enable
    bus_req_t           bus_i      = '0; // register bus request
    logic signed [15:0] level      = 0;  // analog level asked of source
    logic signed [31:0] pos        = 0;  // encoder position asked
    logic signed [31:0] cmd_pos_i  = 0;  // commanded position
    logic signed [15:0] mv;              // analog sample from source
    logic signed [31:0] act;             // encoder position
    logic signed [31:0] spd;             // ramped speed target
    logic [31:0]        rd;              // read data
    logic [15:0]        kp, ti;          // loop gain outputs
    logic               en, flt, irq;    // loop enable, fault, irq
    logic [31:0]        d, prev;         // read value, last speed
    logic [15:0]        rst_v [10] = '{16'h2, 16'hb7, 16'hbd, 16'h0,
        16'h32, 16'h0, 16'h0, 16'h3e8, 16'h64, 16'h64};
    int num_errors = 0;
    int cmp_count  = 0;
    int cyc        = 0;
    always #50 core_clk_i = ~core_clk_i;
    analog_src_model analog_src_model_inst (.core_clk_i(core_clk_i),
        .level_i(level), .pos_i(pos), .mv_o(mv), .act_pos_o(act));
    speed_cmd_path #(.RAMP_CYCLES(20)) speed_cmd_path_inst (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce),
        .bus_i(bus_i), .rd_data_o(rd), .analog_cmd_input_i(mv),
        .cmd_pos_i(cmd_pos_i), .act_pos_i(act), .target_speed_o(spd),
        .loop_prop_gain_o(kp), .loop_integral_time_o(ti),
        .speed_loop_en_o(en), .pos_fault_o(flt), .irq_o(irq));
    // one-cycle write strobe, then an idle cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk_i) bus_i <= '{a, v, 1'b1, 1'b0};
        @(posedge core_clk_i) bus_i <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdr(input logic [3:0] a);
        @(posedge core_clk_i) bus_i <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk_i) bus_i <= '0;
        #1 d = rd;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // bounded wait for the speed to step away from its last value
    task automatic step;
        prev = spd;
        for (int i = 0; i < 60 && spd === prev; i++) idle(1);
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        srst_i <= 0;
        for (int a = 0; a < 10; a++) begin
            rdr(4'(a));
            `CHK("reset value", {16'h0, rst_v[a]}, d)
        end
        `CHK("gains", {16'hb7, 16'hbd}, {kp, ti})
        wr(A_KP, 32'd100);
        wr(A_TI, 32'd30001);  // too large, dropped
        `CHK("gain write", {16'd100, 16'hbd}, {kp, ti})
        @(posedge core_clk_i) ce <= 1'b0;  // frozen: write not taken
        wr(A_KP, 32'd7);
        `CHK("frozen", 16'd100, kp)
        @(posedge core_clk_i) ce <= 1'b1;
        pos <= 32'h20000;
        idle(5);
        `CHK("no fault type 2", {1'b1, 1'b0}, {en, flt})
        wr(A_CTRL_TYPE, 32'd1);
        wr(A_MASK, 32'd3);
        idle(3);
        `CHK("fault type 1", 3'b011, {en, flt, irq})
        pos <= 0;
        wr(A_STATUS, 32'd1);
        idle(2);
        `CHK("fault cleared", 2'b00, {flt, irq})
        @(posedge core_clk_i) cmd_pos_i <= 32'h0000_ffff; // at the limit
        idle(3);
        `CHK("at limit", 1'b0, flt)
        @(posedge core_clk_i) cmd_pos_i <= -32'sh0001_0000; // beyond
        idle(3);
        `CHK("negative error", 1'b1, flt)
        @(posedge core_clk_i) cmd_pos_i <= 0;
        wr(A_STATUS, 32'd1);
        idle(2);
        `CHK("second clear", 1'b0, flt)
        wr(A_CTRL_TYPE, 32'd3);  // illegal code
        rdr(A_CTRL_TYPE);
        `CHK("type kept", 32'd1, d)
        wr(A_CTRL_TYPE, 32'd2);
        wr(A_MODE, 32'd1);  // ramp mode first, so speed starts at zero
        wr(A_INT_SPEED, 32'd250);
        step();
        `CHK("accel 1", 32'd100, spd)
        step();
        `CHK("accel 2", 32'd200, spd)
        step();
        `CHK("accel 3", 32'd250, spd)
        rdr(A_STATUS);
        `CHK("reached", 2'b11, {d[ST_REACHED], irq})
        wr(A_DECEL, 32'd50);
        wr(A_INT_SPEED, 32'd0);
        step();
        `CHK("decel", 32'd200, spd)
        wr(A_MODE, 32'd0);
        wr(A_OFFSET, 32'd100);
        wr(A_DEADBAND, 32'd40);
        wr(A_LOWPASS, 32'd0);
        wr(A_SOURCE, 32'd1);
        level <= 16'sd5100;
        idle(2100);
        `CHK("scaled", 32'd25000, spd)
        level <= 16'sd140;  // corrects to the deadband edge
        idle(1100);
        `CHK("deadband", 32'd0, spd)
        wr(A_LOWPASS, 32'd1000);
        level <= 16'sd5100;
        idle(1100);
        `CHK("filtered", 1'b1, (spd > 0 && spd < 25000))
        wr(A_SOURCE, 32'd0);
        wr(A_MODE, 32'd2);
        wr(A_SOURCE, 32'd0);
        rdr(A_SOURCE);
        `CHK("forced source", 32'd1, d)
        end_sim();
    end
endmodule
